// *** include/sleep_lockup_regs.svh ***
// Purpose: constants for the sleep, wake and lockup controller
// Assumes: one clock, synchronous active-low reset
// Notes: wake hold is given in ns and rounded up to whole clock cycles
`ifndef SLEEP_LOCKUP_REGS_SVH
`define SLEEP_LOCKUP_REGS_SVH
`define EVENT_REG_RESET   1'b0
`define MASK_PEND_RESET   1'b0
`define EVT_EDGE_RESET    1'b0
`define WAKE_HOLD_NS      100
`define CLK_PERIOD_NS     100
`define WAKE_HOLD_CYCLES  ((`WAKE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** include/sleep_lockup_pkg.sv ***
// Purpose: types for the sleep, wake and lockup controller
// Assumes: nothing
// Notes: one-hot state codes
package sleep_lockup_pkg;
	typedef enum logic [4:0] {
		ST_RUN        = 5'b0_0001,
		ST_SLEEP_WFI  = 5'b0_0010,
		ST_SLEEP_WFE  = 5'b0_0100,
		ST_LOCKUP     = 5'b0_1000,
		ST_WAKE_HOLD  = 5'b1_0000
	} core_state_e;
	typedef enum logic [1:0] {
		CAUSE_NONE  = 2'b00,
		CAUSE_NMI   = 2'b01,
		CAUSE_HARD  = 2'b10
	} handler_ctx_e;
endpackage

// *** hw/event_latch.sv ***
// Purpose: the one-bit internal event register
// Assumes: inputs synchronous to sys_clk
// Notes: no software path reaches this bit
`timescale 1ns/100ps
`include "sleep_lockup_regs.svh"
module event_latch (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// set and clear
	input  wire logic set_evt,
	input  wire logic clr_evt,
	// state
	output logic      evt_r
);
	import sleep_lockup_pkg::*;
	typedef struct packed {
		logic evt;
	} latch_s;
	latch_s state_r;
	latch_s state_nxt;
	// set wins over clear so no event is lost
	always_comb begin
		state_nxt = state_r;
		if (clr_evt)
			state_nxt.evt = 1'b0;
		if (set_evt)
			state_nxt.evt = 1'b1;
	end
	// register
	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			state_r <= '{evt: `EVENT_REG_RESET};
		else
			state_r <= state_nxt;
	end
	assign evt_r = state_r.evt;
	AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
		set_evt |=> evt_r) else $error("event set was lost");
endmodule

// *** hw/core_sleep_wake_lockup_ctrl.sv ***
// Purpose: processor sleep entry, wakeup and lockup control
// Assumes: all inputs synchronous to sys_clk; instr strobes are one-cycle pulses
// Notes: exception logic supplies priority decisions as single bits
// Operation
// R1 - hard fault in nmi or hardfault handler locks
// R2 - lockup stops instruction issue
// R3 - leave lockup on reset, nmi or halt
// R4 - lockup from nmi ignores later nmi
// R5 - light sleep gates core clock only
// R6 - deep select chooses light or deep
// R7 - wfi sleeps unless wake already true
// R8 - wfe tests event, sleeps or clears
// R9 - event register internal, no software access
// R10 - sleep on handler exit returns and sleeps
// R11 - wfi sleep wakes on sufficient exception
// R12 - masked interrupt wakes, handler deferred
// R13 - wfe wakes on exception, event, sev
// R14 - new pending wakes when event_on_new_pending set
// R15 - external event wakes or sets event
// R16 - spurious wake tolerated, e.g. debug
// R17 - only reset and nmi preempt hardfault
// R18 - status outputs lockup, light, deep sleep
`timescale 1ns/100ps
`include "sleep_lockup_regs.svh"
module core_sleep_wake_lockup_ctrl (
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// system control word bits
	input  wire logic                          deep_sleep_select,
	input  wire logic                          sleep_on_handler_exit,
	input  wire logic                          event_on_new_pending,
	// mask bits
	input  wire logic                          interrupt_mask_bit,
	input  wire logic                          fault_mask_bit,
	// instruction strobes from execute
	input  wire logic                          wait_for_interrupt_instr,
	input  wire logic                          wait_for_event_instr,
	input  wire logic                          handler_exit_to_thread,
	// exception logic
	input  wire logic                          exc_entry_ok,
	input  wire logic                          irq_enabled_higher,
	input  wire logic                          irq_new_pending,
	input  wire logic                          nmi_req,
	input  wire logic                          hard_fault_req,
	input  wire sleep_lockup_pkg::handler_ctx_e handler_ctx,
	// external events and debug
	input  wire logic                          ext_event_in,
	input  wire logic                          peer_send_event_instr,
	input  wire logic                          debug_halt_req,
	input  wire logic                          debug_wake,
	// outputs to core and system
	output logic                               instr_issue_en,
	output logic                               core_clk_gate,
	output logic                               deep_sleep_req,
	output logic                               lockup_status,
	output logic                               light_sleep_status,
	output logic                               deep_sleep_status,
	output logic                               irq_handler_defer
);
	import sleep_lockup_pkg::*;

	typedef struct packed {
		core_state_e state;
		logic        deep;
		logic        lock_from_nmi;
		logic        evt_edge;
		logic        issue_en;
		logic        clk_gate;
		logic        deep_req;
		logic        lock_st;
		logic        light_st;
		logic        deep_st;
		logic        defer;
	} ctrl_s;

	ctrl_s st_r;
	ctrl_s st_nxt;
	logic  evt_r;
	logic  evt_set;
	logic  evt_clr;
	logic  ext_rise;
	logic  wfi_wake;
	logic  wfe_wake;
	logic  lock_entry;
	logic  lock_exit;

	// exception wake qualifier shared by both sleep kinds
	function automatic logic exc_wake(input logic entry_ok, input logic irq_hi,
		input logic pmask, input logic fmask);
		exc_wake = entry_ok | (irq_hi & pmask & ~fmask);
	endfunction

	// wake causes
	assign ext_rise = ext_event_in & ~st_r.evt_edge;
	assign wfi_wake = exc_wake(exc_entry_ok, irq_enabled_higher, interrupt_mask_bit,
		fault_mask_bit) | debug_wake; // R11 R12 R16
	assign wfe_wake = wfi_wake | ext_rise | peer_send_event_instr
		| (event_on_new_pending & irq_new_pending); // R13 R14 R15

	// lockup entry and release
	assign lock_entry = hard_fault_req & (handler_ctx != CAUSE_NONE); // R1 R17
	assign lock_exit  = debug_halt_req | (nmi_req & ~st_r.lock_from_nmi); // R3 R4

	// event register control: set by any event while not consumed by a wake
	assign evt_set = (ext_rise | peer_send_event_instr | (event_on_new_pending & irq_new_pending))
		& (st_r.state != ST_SLEEP_WFE); // R15 R14
	assign evt_clr = wait_for_event_instr & ~wait_for_interrupt_instr & ~lock_entry
		& (st_r.state == ST_RUN) & evt_r; // R8

	// internal event bit, no software path
	event_latch u_event_latch (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.set_evt (evt_set),
		.clr_evt (evt_clr),
		.evt_r   (evt_r)
	); // R9

	// next state
	always_comb begin
		st_nxt          = st_r;
		st_nxt.evt_edge = ext_event_in;
		case (st_r.state)
			ST_RUN: begin
				if (lock_entry) begin
					st_nxt.state         = ST_LOCKUP; // R1
					st_nxt.lock_from_nmi = (handler_ctx == CAUSE_NMI); // R4
				end else if (wait_for_interrupt_instr) begin
					// a wake cause in the same cycle cancels the sleep
					if (!wfi_wake) begin
						st_nxt.state = ST_SLEEP_WFI; // R7
						st_nxt.deep  = deep_sleep_select; // R6
					end
				end else if (wait_for_event_instr) begin
					// a set event bit is spent instead of sleeping
					if (!evt_r && !wfe_wake) begin
						st_nxt.state = ST_SLEEP_WFE; // R8
						st_nxt.deep  = deep_sleep_select; // R6
					end
				end else if (handler_exit_to_thread && sleep_on_handler_exit && !wfi_wake) begin
					st_nxt.state = ST_SLEEP_WFI; // R10
					st_nxt.deep  = deep_sleep_select;
				end
			end
			ST_SLEEP_WFI: begin
				if (wfi_wake)
					st_nxt.state = ST_WAKE_HOLD; // R11
			end
			ST_SLEEP_WFE: begin
				if (wfe_wake)
					st_nxt.state = ST_WAKE_HOLD; // R13
			end
			ST_LOCKUP: begin
				if (lock_exit) begin
					st_nxt.state         = ST_RUN; // R3
					st_nxt.lock_from_nmi = 1'b0;
				end
			end
			ST_WAKE_HOLD: begin
				st_nxt.state = ST_RUN;
			end
			default: begin
				st_nxt.state = ST_RUN;
			end
		endcase
		// registered outputs follow the next state; defer follows the mask and interrupt inputs
		st_nxt.issue_en = (st_nxt.state == ST_RUN); // R2
		st_nxt.clk_gate = (st_nxt.state == ST_SLEEP_WFI) || (st_nxt.state == ST_SLEEP_WFE); // R5
		st_nxt.deep_req = st_nxt.clk_gate & st_nxt.deep; // R5
		st_nxt.lock_st  = (st_nxt.state == ST_LOCKUP); // R18
		st_nxt.light_st = st_nxt.clk_gate & ~st_nxt.deep; // R18
		st_nxt.deep_st  = st_nxt.deep_req; // R18
		st_nxt.defer    = interrupt_mask_bit & ~fault_mask_bit & irq_enabled_higher; // R12
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r <= '{state: ST_RUN, deep: 1'b0, lock_from_nmi: 1'b0,
				evt_edge: `EVT_EDGE_RESET, issue_en: 1'b1, clk_gate: 1'b0,
				deep_req: 1'b0, lock_st: 1'b0, light_st: 1'b0,
				deep_st: 1'b0, defer: `MASK_PEND_RESET};
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flops
	assign instr_issue_en     = st_r.issue_en;
	assign core_clk_gate      = st_r.clk_gate;
	assign deep_sleep_req     = st_r.deep_req;
	assign lockup_status      = st_r.lock_st;
	assign light_sleep_status = st_r.light_st;
	assign deep_sleep_status  = st_r.deep_st;
	assign irq_handler_defer  = st_r.defer;

	// checks, one per guarded behaviour
	// a hard fault inside either handler locks the core
	AST_LOCK_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
		(st_r.state == ST_RUN) && lock_entry
		|=> lockup_status)
		else $error("no lockup");

	// nothing issues while locked
	AST_LOCK_NO_ISSUE: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
		lockup_status
		|-> !instr_issue_en)
		else $error("issue during lockup");

	// issue only while neither asleep nor locked
	AST_ISSUE_RUN_ONLY: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
		instr_issue_en
		|-> !core_clk_gate && !lockup_status)
		else $error("issue while halted");

	// lockup holds without a release cause
	AST_LOCK_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
		lockup_status && !debug_halt_req && !nmi_req
		|=> lockup_status)
		else $error("lockup left");

	// an allowed nmi releases lockup
	AST_LOCK_NMI_EXIT: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
		lockup_status && nmi_req && !st_r.lock_from_nmi
		|=> !lockup_status && instr_issue_en)
		else $error("nmi did not release lockup");

	// a debugger halt releases lockup
	AST_LOCK_HALT_EXIT: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
		lockup_status && debug_halt_req
		|=> !lockup_status && instr_issue_en)
		else $error("halt did not release lockup");

	// lockup taken from the nmi handler ignores nmi
	AST_NMI_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
		lockup_status && st_r.lock_from_nmi && !debug_halt_req
		|=> lockup_status)
		else $error("nmi released nmi lockup");

	// the nmi context is remembered at lockup entry
	AST_NMI_CTX_LOCK: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
		(st_r.state == ST_RUN) && lock_entry && (handler_ctx == CAUSE_NMI)
		|=> st_r.lock_from_nmi)
		else $error("nmi context lost");

	// never both sleep kinds at once
	AST_LIGHT_DEEP: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
		!(light_sleep_status && deep_sleep_status))
		else $error("both sleep kinds");

	// system clocks are only asked to stop while asleep
	AST_DEEP_REQ: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
		deep_sleep_req
		|-> core_clk_gate)
		else $error("deep request while awake");

	// sleep depth follows the select bit at entry
	AST_DEEP_SEL: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
		(st_r.state == ST_RUN) && wait_for_interrupt_instr && !wfi_wake && !lock_entry
		|=> (deep_sleep_req == $past(deep_sleep_select)))
		else $error("wrong sleep depth");

	// wfi sleeps at once when no wake is pending
	AST_WFI_SLEEP: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
		(st_r.state == ST_RUN) && wait_for_interrupt_instr && !wfi_wake && !lock_entry
		|=> core_clk_gate)
		else $error("wfi did not sleep");

	// wfi with a wake already pending keeps running
	AST_WFI_NO_SLEEP: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
		(st_r.state == ST_RUN) && wait_for_interrupt_instr && wfi_wake && !lock_entry
		|=> !core_clk_gate && instr_issue_en)
		else $error("wfi slept with wake pending");

	// wfe with the event bit set does not sleep
	AST_WFE_SKIP: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
		(st_r.state == ST_RUN) && wait_for_event_instr && evt_r && !lock_entry && !wait_for_interrupt_instr
		|=> !core_clk_gate)
		else $error("wfe slept with event set");

	// wfe with the event bit clear sleeps
	AST_WFE_SLEEP: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
		(st_r.state == ST_RUN) && wait_for_event_instr && !evt_r && !wfe_wake
		&& !wait_for_interrupt_instr && !lock_entry |=> core_clk_gate)
		else $error("wfe did not sleep");

	// wfe spends a set event bit
	AST_WFE_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
		(st_r.state == ST_RUN) && wait_for_event_instr && evt_r && !evt_set
		&& !wait_for_interrupt_instr && !lock_entry |=> !evt_r)
		else $error("event bit not spent");

	// handler exit with sleep on exit set sleeps
	AST_SOE_SLEEP: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
		(st_r.state == ST_RUN) && handler_exit_to_thread && sleep_on_handler_exit && !wfi_wake
		&& !lock_entry && !wait_for_interrupt_instr && !wait_for_event_instr |=> core_clk_gate)
		else $error("no sleep on handler exit");

	// wfi sleep holds until an exception may enter
	AST_WFI_STAY: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
		(st_r.state == ST_SLEEP_WFI) && !wfi_wake
		|=> core_clk_gate)
		else $error("wfi sleep left early");

	// a qualifying exception ends wfi sleep
	AST_WFI_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
		(st_r.state == ST_SLEEP_WFI) && wfi_wake
		|=> !core_clk_gate ##1 instr_issue_en)
		else $error("wfi wake missed");

	// a masked higher interrupt defers its handler
	AST_DEFER_SET: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
		interrupt_mask_bit && !fault_mask_bit && irq_enabled_higher
		|=> irq_handler_defer)
		else $error("handler not deferred");

	// any wfe wake cause ends wfe sleep
	AST_WFE_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
		(st_r.state == ST_SLEEP_WFE) && wfe_wake
		|=> !core_clk_gate ##1 instr_issue_en)
		else $error("wfe wake missed");

	// a new pending interrupt wakes when enabled as event
	AST_PEND_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
		(st_r.state == ST_SLEEP_WFE) && event_on_new_pending && irq_new_pending
		|=> !core_clk_gate)
		else $error("pending event did not wake");

	// an external event while running sets the event bit
	AST_EXT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
		(st_r.state == ST_RUN) && ext_rise
		|=> evt_r)
		else $error("external event not stored");

	// a spurious wake source ends any sleep
	AST_SPURIOUS: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
		core_clk_gate && debug_wake
		|=> !core_clk_gate)
		else $error("debug wake missed");

	// ordinary exceptions cannot preempt lockup
	AST_LOCK_NO_PREEMPT: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
		lockup_status && exc_entry_ok && !debug_halt_req && !nmi_req
		|=> lockup_status && !instr_issue_en)
		else $error("exception preempted lockup");

	// while asleep exactly one sleep status shows
	AST_STATUS_ONE: assert property (@(posedge sys_clk) disable iff (!rst_n) // R18
		core_clk_gate
		|-> (light_sleep_status != deep_sleep_status))
		else $error("sleep status missing");
endmodule

// *** testbench/exc_event_model.sv ***
// Purpose: far-side model of the exception logic and the event controller
// Assumes: commands come from the bench at the falling edge
// Notes: answers one cycle late, or four when slow is high
`timescale 1ns/100ps
module exc_event_model (
	// clock
	input  wire logic sys_clk,
	// commands from the bench
	input  wire logic want_exc,
	input  wire logic want_evt,
	input  wire logic slow,
	// toward the block
	output logic      exc_entry_ok,
	output logic      ext_event_in
);
	logic [3:0] exc_q = 4'h0;
	logic [3:0] evt_q = 4'h0;
	// delay lines give a prompt or a late answer
	always @(posedge sys_clk) begin
		exc_q <= {exc_q[2:0], want_exc};
		evt_q <= {evt_q[2:0], want_evt};
	end
	assign exc_entry_ok = slow ? exc_q[3] : exc_q[0];
	assign ext_event_in = slow ? evt_q[3] : evt_q[0];
endmodule

// *** testbench/core_sleep_wake_lockup_ctrl_tb.sv ***
// Purpose: self-checking bench for the sleep, wake and lockup controller
// Assumes: inputs change at the falling edge, outputs are registered and change at the taking edge
// Notes: outputs are compared as one vector, masked where a state leaves a bit open
`timescale 1ns/100ps
module core_sleep_wake_lockup_ctrl_tb;
	import sleep_lockup_pkg::*;
	logic         sys_clk = 1'b0, rst_n = 1'b0, deep_sleep_select = 1'b0, sleep_on_handler_exit = 1'b0;
	logic         event_on_new_pending = 1'b0, interrupt_mask_bit = 1'b0, fault_mask_bit = 1'b0;
	logic         irq_enabled_higher = 1'b0, nmi_req = 1'b0, want_exc = 1'b0, want_evt = 1'b0, slow = 1'b1;
	logic         exc_entry_ok, ext_event_in, instr_issue_en, core_clk_gate, deep_sleep_req, lockup_status;
	logic         light_sleep_status, deep_sleep_status, irq_handler_defer;
	logic [7:0]   stb = 8'h00;
	logic [6:0]   o;
	handler_ctx_e handler_ctx = CAUSE_NONE;
	int           fails = 0, n_compared = 0, cyc = 0;
	// all outputs in one vector: issue, gate, deep req, lockup, light, deep, defer
	assign o = {instr_issue_en, core_clk_gate, deep_sleep_req, lockup_status,
		light_sleep_status, deep_sleep_status, irq_handler_defer};
	always #50 sys_clk = ~sys_clk;
	// design and far-side model
	core_sleep_wake_lockup_ctrl dut (.sys_clk, .rst_n, .deep_sleep_select, .sleep_on_handler_exit,
		.event_on_new_pending, .interrupt_mask_bit, .fault_mask_bit, .wait_for_interrupt_instr(stb[0]),
		.wait_for_event_instr(stb[1]), .handler_exit_to_thread(stb[2]), .exc_entry_ok, .irq_enabled_higher,
		.irq_new_pending(stb[7]), .nmi_req, .hard_fault_req(stb[3]), .handler_ctx, .ext_event_in,
		.peer_send_event_instr(stb[4]), .debug_halt_req(stb[5]), .debug_wake(stb[6]), .instr_issue_en,
		.core_clk_gate, .deep_sleep_req, .lockup_status, .light_sleep_status, .deep_sleep_status,
		.irq_handler_defer);
	exc_event_model partner (.sys_clk, .want_exc, .want_evt, .slow, .exc_entry_ok, .ext_event_in);
	task wc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// one-cycle strobe on bit b
	task pulse(input int b);
		@(negedge sys_clk);
		stb[b] = 1'b1;
		@(negedge sys_clk);
		stb[b] = 1'b0;
	endtask
	task chk(input logic [6:0] s, input logic [6:0] e, input logic [6:0] m = 7'h7f);
		n_compared++;
		if ((s & m) !== (e & m)) begin
			fails++;
			$display("mismatch at %0t: outputs %b, expected %b", $time, s, e);
		end
	endtask
	task end_sim;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard, tests need about 130 cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			end_sim();
		end
	end
	// test sequence
	initial begin
		wc(12);
		rst_n = 1'b1;
		wc(1);
		chk(o, 7'h40);
		pulse(0); wc(2); chk(o, 7'h24);
		want_exc = 1'b1; wc(8); chk(o, 7'h40);
		want_exc = 1'b0; wc(6);
		$display("test light sleep done");
		deep_sleep_select = 1'b1; pulse(0); wc(2); chk(o, 7'h32);
		pulse(6); wc(4); chk(o, 7'h40);
		deep_sleep_select = 1'b0;
		pulse(1); wc(2); chk(o, 7'h24);
		pulse(4); wc(4); chk(o, 7'h40);
		$display("test deep and event sleep done");
		slow = 1'b0; want_evt = 1'b1; wc(3); want_evt = 1'b0; wc(3);
		pulse(1); wc(2); chk(o, 7'h40);
		pulse(1); wc(2); chk(o, 7'h24);
		want_evt = 1'b1; wc(5); chk(o, 7'h40);
		want_evt = 1'b0; wc(3);
		event_on_new_pending = 1'b1; pulse(1); wc(2); chk(o, 7'h24);
		pulse(7); wc(4); chk(o, 7'h40);
		event_on_new_pending = 1'b0;
		$display("test external events done");
		sleep_on_handler_exit = 1'b1; pulse(2); sleep_on_handler_exit = 1'b0; wc(2); chk(o, 7'h24);
		pulse(6); wc(4);
		pulse(0); wc(2); chk(o, 7'h24);
		interrupt_mask_bit = 1'b1; irq_enabled_higher = 1'b1; wc(3); chk(o, 7'h41);
		fault_mask_bit = 1'b1; wc(2); chk(o, 7'h00, 7'h01);
		interrupt_mask_bit = 1'b0; fault_mask_bit = 1'b0; irq_enabled_higher = 1'b0;
		$display("test handler exit and mask done");
		handler_ctx = CAUSE_HARD; pulse(3); wc(2); chk(o, 7'h08, 7'h48);
		handler_ctx = CAUSE_NONE; wc(4); chk(o, 7'h08, 7'h48);
		nmi_req = 1'b1; wc(3); nmi_req = 1'b0; wc(3); chk(o, 7'h40, 7'h48);
		handler_ctx = CAUSE_NMI; pulse(3); wc(2); nmi_req = 1'b1; wc(3); chk(o, 7'h08, 7'h48);
		nmi_req = 1'b0; handler_ctx = CAUSE_NONE; pulse(5); wc(3); chk(o, 7'h40, 7'h48);
		$display("test lockup done");
		end_sim();
	end
endmodule
